// ---- hdl/bwsc_top.sv ----
// Wait-state controller: decides how many bus states each external access takes.
// Assumes a bus sequencer pulses cyc_start with area and kind, and waits for cyc_done.
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module bwsc_top
   import bwsc_pkg::*;
#(
   parameter int AREAS = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [BWSC_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cyc_start,
   input wire logic [2:0] cyc_area,
   input wire logic [2:0] cyc_kind,
   input wire logic cyc_internal,
   input wire logic wait_n,
   output logic cyc_busy,
   output logic cyc_done,
   output logic [3:0] cyc_states
);
   logic [15:0] cpu_wait_q;
   logic [15:0] dma_wait_q;
   logic [15:0] long_wait_q;
   logic [15:0] area_ctrl_q;
   logic [15:0] refresh_q;
   logic ack_q;
   logic [15:0] wdata;
   logic [15:0] wmask;
   logic wr_go;
   logic [15:0] rd_mux;
   bwsc_state_t state_q;
   logic [3:0] cnt_q;
   logic samp_q;
   logic [3:0] total_q;
   logic [AREAS-1:0] sel_bit;
   logic [AREAS-1:0] area_samp;
   logic [3:0] area_base [AREAS];
   logic [3:0] lw02;
   logic [3:0] lw6;
   logic [3:0] ref_wait;
   logic area1_dram_select;
   logic area6_mux_io;
   logic dram_write_pitch_bit;
   logic [3:0] req_base;
   logic req_samp;
   logic wr_cpu;
   logic wr_dma;
   logic wr_long;
   logic wr_area;
   logic wr_ref;
   logic take;
   logic last;
   logic stretch;

   // One wait state on every access keeps readdata a flop and decode off the bus path
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   // Writes land at the edge where the master sees waitrequest low
   assign wr_go = avs_write & ack_q;
   assign wr_cpu = wr_go & (avs_address == BWSC_OFS_CPU_WAIT);
   assign wr_dma = wr_go & (avs_address == BWSC_OFS_DMA_WAIT);
   assign wr_long = wr_go & (avs_address == BWSC_OFS_LONG_WAIT);
   assign wr_area = wr_go & (avs_address == BWSC_OFS_AREA_CTRL);
   assign wr_ref = wr_go & (avs_address == BWSC_OFS_REFRESH);
   assign wdata = avs_writedata[15:0];
   assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // Power-on reset only; nothing else reinitialises these registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_wait_q <= BWSC_CPU_WAIT_RST;
      end else if (wr_cpu) begin
         // Pitch bit stored as written; keeping it set for SRAM is software's job
         cpu_wait_q <= (cpu_wait_q & ~(wmask & BWSC_CPU_WAIT_WMASK))
            | (wdata & wmask & BWSC_CPU_WAIT_WMASK);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_wait_q <= BWSC_DMA_WAIT_RST;
      end else if (wr_dma) begin
         dma_wait_q <= (dma_wait_q & ~wmask) | (wdata & wmask);
      end
   end

   // Pull-up control bit is not kept; the pin is modelled outside
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         long_wait_q <= BWSC_LONG_WAIT_RST;
      end else if (wr_long) begin
         long_wait_q <= (long_wait_q & ~(wmask & BWSC_LONG_WAIT_WMASK))
            | (wdata & wmask & BWSC_LONG_WAIT_WMASK);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         area_ctrl_q <= BWSC_AREA_CTRL_RST;
      end else if (wr_area) begin
         area_ctrl_q <= (area_ctrl_q & ~(wmask & BWSC_AREA_CTRL_WMASK))
            | (wdata & wmask & BWSC_AREA_CTRL_WMASK);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refresh_q <= BWSC_REFRESH_RST;
      end else if (wr_ref) begin
         refresh_q <= (refresh_q & ~(wmask & BWSC_REFRESH_WMASK))
            | (wdata & wmask & BWSC_REFRESH_WMASK);
      end
   end

   always_comb begin
      case (avs_address)
         BWSC_OFS_CPU_WAIT: rd_mux = cpu_wait_q | BWSC_CPU_WAIT_ONES;
         BWSC_OFS_DMA_WAIT: rd_mux = dma_wait_q;
         BWSC_OFS_LONG_WAIT: rd_mux = long_wait_q;
         BWSC_OFS_AREA_CTRL: rd_mux = area_ctrl_q;
         BWSC_OFS_REFRESH: rd_mux = refresh_q;
         BWSC_OFS_STATUS: rd_mux = {5'h00, state_q, samp_q, cnt_q, total_q};
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~ack_q) begin
         avs_readdata <= {16'h0000, rd_mux};
      end
   end

   assign area1_dram_select = area_ctrl_q[BWSC_AREA1_DRAM_SELECT_BIT];
   assign area6_mux_io = area_ctrl_q[BWSC_AREA6_MUX_IO_BIT];
   assign dram_write_pitch_bit = cpu_wait_q[BWSC_DRAM_WRITE_PITCH_BIT];
   // Codes 0..3 stand for 1..4 inserted states
   assign lw02 = {2'b00, long_wait_q[BWSC_AREA02_LW_LSB +: 2]} + 4'h1;
   assign lw6 = {2'b00, long_wait_q[BWSC_AREA6_LW_LSB +: 2]} + 4'h1;
   assign ref_wait = {2'b00, refresh_q[1:0]} + 4'h1;

   // Per-area control bit chosen by the kind of cycle
   generate
      for (genvar s = 0; s < AREAS; s++) begin : g_sel
         always_comb begin
            case (cyc_kind)
               BWSC_K_CPU_RD: sel_bit[s] = cpu_wait_q[8 + s];
               BWSC_K_DMA_RD: sel_bit[s] = dma_wait_q[8 + s];
               BWSC_K_DMA_WR: sel_bit[s] = dma_wait_q[s];
               // Only area 1 has a write control bit; others always sample
               BWSC_K_CPU_WR: sel_bit[s] = (s == 1) ? dram_write_pitch_bit : 1'b1;
               default: sel_bit[s] = 1'b1;
            endcase
         end
      end
   endgenerate

   generate
      for (genvar a = 0; a < AREAS; a++) begin : g_area
         always_comb begin
            if (cyc_internal) begin
               area_base[a] = (a == 5) ? BWSC_ST_PERIPH : BWSC_ST_ONE;
               area_samp[a] = 1'b0;
            end else if (a == 6 && area6_mux_io) begin
               area_base[a] = BWSC_ST_MUX_IO;
               area_samp[a] = 1'b1;
            end else if (a == 1 && area1_dram_select) begin
               area_base[a] = sel_bit[a] ? BWSC_ST_TWO : BWSC_ST_ONE;
               area_samp[a] = sel_bit[a];
            end else if (a == 0 || a == 2) begin
               area_base[a] = BWSC_ST_ONE + lw02;
               area_samp[a] = sel_bit[a];
            end else if (a == 6) begin
               area_base[a] = BWSC_ST_ONE + lw6;
               area_samp[a] = sel_bit[a];
            end else begin
               area_base[a] = sel_bit[a] ? BWSC_ST_TWO : BWSC_ST_ONE;
               area_samp[a] = sel_bit[a];
            end
         end
      end
   endgenerate

   always_comb begin
      if (cyc_kind == BWSC_K_REFRESH) begin
         // Refresh follows the area-1 read pitch bit, never the wait input
         req_base = cpu_wait_q[9] ? (BWSC_ST_TWO + ref_wait) : BWSC_ST_ONE;
         req_samp = 1'b0;
      end else begin
         req_base = area_base[cyc_area];
         req_samp = area_samp[cyc_area];
      end
   end

   // Cycle engine: counts fixed states, then stretches the last while wait_n is low
   // A wait request seen before the last fixed state is not counted; the sequencer
   // only offers the input there, which keeps the count independent of early glitches
   assign take = (state_q == BWSC_IDLE) & cyc_start;
   assign last = (state_q == BWSC_RUN) & (cnt_q <= 4'h1);
   assign stretch = last & samp_q & ~wait_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= BWSC_IDLE;
      end else begin
         case (state_q)
            BWSC_IDLE: begin
               if (take) begin
                  state_q <= BWSC_RUN;
               end
            end
            BWSC_RUN: begin
               if (last && !stretch) begin
                  state_q <= BWSC_DONE;
               end
            end
            BWSC_DONE: begin
               state_q <= BWSC_IDLE;
            end
            default: begin
               state_q <= BWSC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
      end else if (take) begin
         cnt_q <= req_base;
      end else if (state_q == BWSC_RUN && cnt_q > 4'h1) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end

   // Sampling choice is frozen at the start so a register write mid-cycle cannot change it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_q <= 1'b0;
      end else if (take) begin
         samp_q <= req_samp;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         total_q <= 4'h0;
      end else if (take) begin
         total_q <= 4'h1;
      end else if (state_q == BWSC_RUN && (cnt_q > 4'h1 || stretch)) begin
         total_q <= total_q + 4'h1;
      end
   end

   assign cyc_busy = (state_q != BWSC_IDLE);
   assign cyc_done = (state_q == BWSC_DONE);
   assign cyc_states = total_q;
endmodule : bwsc_top

// ---- common/bwsc_pkg.sv ----
// Shared constants for the bus wait-state control block.
// Assumes a 32-bit Avalon-MM register slave with word addressing by byte offset.
package bwsc_pkg;
   localparam int BWSC_AW = 5;
   localparam logic [4:0] BWSC_OFS_CPU_WAIT = 5'h00;
   localparam logic [4:0] BWSC_OFS_DMA_WAIT = 5'h04;
   localparam logic [4:0] BWSC_OFS_LONG_WAIT = 5'h08;
   localparam logic [4:0] BWSC_OFS_AREA_CTRL = 5'h0C;
   localparam logic [4:0] BWSC_OFS_REFRESH = 5'h10;
   localparam logic [4:0] BWSC_OFS_STATUS = 5'h14;
   localparam logic [15:0] BWSC_CPU_WAIT_RST = 16'hFFFF;
   localparam logic [15:0] BWSC_CPU_WAIT_ONES = 16'h00FD;
   localparam logic [15:0] BWSC_CPU_WAIT_WMASK = 16'hFF02;
   localparam logic [15:0] BWSC_DMA_WAIT_RST = 16'hFFFF;
   localparam logic [15:0] BWSC_LONG_WAIT_RST = 16'h7800;
   localparam logic [15:0] BWSC_LONG_WAIT_WMASK = 16'h7800;
   localparam logic [15:0] BWSC_AREA_CTRL_RST = 16'h0000;
   localparam logic [15:0] BWSC_AREA_CTRL_WMASK = 16'hC000;
   localparam logic [15:0] BWSC_REFRESH_RST = 16'h0000;
   localparam logic [15:0] BWSC_REFRESH_WMASK = 16'h0003;
   localparam int BWSC_DRAM_WRITE_PITCH_BIT = 1;
   localparam int BWSC_AREA1_DRAM_SELECT_BIT = 15;
   localparam int BWSC_AREA6_MUX_IO_BIT = 14;
   localparam int BWSC_AREA02_LW_LSB = 13;
   localparam int BWSC_AREA6_LW_LSB = 11;
   localparam logic [3:0] BWSC_ST_ONE = 4'h1;
   localparam logic [3:0] BWSC_ST_TWO = 4'h2;
   localparam logic [3:0] BWSC_ST_PERIPH = 4'h3;
   localparam logic [3:0] BWSC_ST_MUX_IO = 4'h4;
   typedef enum logic [2:0] {
      BWSC_K_CPU_RD = 3'h0,
      BWSC_K_CPU_WR = 3'h1,
      BWSC_K_DMA_RD = 3'h2,
      BWSC_K_DMA_WR = 3'h3,
      BWSC_K_REFRESH = 3'h4
   } bwsc_kind_t;
   typedef enum logic [1:0] {
      BWSC_IDLE = 2'b00,
      BWSC_RUN = 2'b01,
      BWSC_DONE = 2'b11
   } bwsc_state_t;
endpackage : bwsc_pkg

// ---- tb/bwsc_mem_model.sv ----
// Far-side memory: answers each access with a commanded run of low wait samples.
// Assumes cyc_busy marks the strobe of an external access.
`timescale 1ns/1ps
module bwsc_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cyc_busy,
   input wire logic [3:0] hold,
   output logic wait_n
);
   logic [3:0] cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_q <= 4'h0;
      else cnt_q <= cyc_busy ? cnt_q + 4'h1 : 4'h0;
   end
   // Between accesses the pulled-up line reads high
   assign wait_n = !(cyc_busy && cnt_q < hold);
endmodule : bwsc_mem_model

// ---- tb/bwsc_checker.sv ----
// Port checks of the wait-state controller.
// Assumes one clock and the register map of bwsc_pkg.
`timescale 1ns/1ps
module bwsc_checker
   import bwsc_pkg::*;
#(
   parameter int AREAS = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [BWSC_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic cyc_start,
   input wire logic [2:0] cyc_area,
   input wire logic [2:0] cyc_kind,
   input wire logic cyc_internal,
   input wire logic cyc_busy,
   input wire logic cyc_done,
   input wire logic [3:0] cyc_states
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      cyc_start && !cyc_busy && !cyc_done;
   endsequence
   AST_BUS_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus wait too long");
   AST_CPU_ONES: assert property (avs_read && avs_waitrequest && avs_address == BWSC_OFS_CPU_WAIT |=> avs_readdata[7:2] == 6'h3F && avs_readdata[0])
      else $error("fixed ones lost");
   AST_TAKE: assert property (s_take |=> cyc_busy && cyc_states == 4'h1)
      else $error("start not taken");
   AST_COUNT: assert property (cyc_busy && !cyc_done && $past(cyc_busy) && !$past(cyc_done) |-> cyc_states == $past(cyc_states) + 4'h1)
      else $error("state count skipped");
   AST_ROM: assert property (s_take ##0 (cyc_internal && cyc_area != 3'h5) |-> ##2 (cyc_done && cyc_states == 4'h1))
      else $error("on-chip memory not one state");
   AST_PERIPH: assert property (s_take ##0 (cyc_internal && cyc_area == 3'h5) |-> ##4 (cyc_done && cyc_states == 4'h3))
      else $error("peripheral not three states");
   AST_REFRESH: assert property (s_take ##0 (cyc_kind == 3'h4) |-> ##[2:7] cyc_done)
      else $error("refresh waited on input");
   AST_DONE_ONE: assert property (cyc_done |=> !cyc_done)
      else $error("done too long");
   AST_HOLD: assert property (cyc_done && !cyc_start |=> $stable(cyc_states))
      else $error("count not held");
endmodule : bwsc_checker
bind bwsc_top bwsc_checker #(.AREAS(AREAS)) u_chk (.clk(clk), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cyc_start(cyc_start),
   .cyc_area(cyc_area), .cyc_kind(cyc_kind), .cyc_internal(cyc_internal),
   .cyc_busy(cyc_busy), .cyc_done(cyc_done), .cyc_states(cyc_states));

// ---- tb/bus_wait_state_control_tb.sv ----
// Self-checking bench of the wait-state controller.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ps
module bus_wait_state_control_tb;
   import bwsc_pkg::*;
   logic clk, rst_n, avs_read, avs_write, avs_waitrequest, cyc_start, cyc_internal, wait_n;
   logic cyc_busy, cyc_done;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, cyc_states, hold;
   logic [2:0] cyc_area, cyc_kind;
   logic [15:0] rd;
   int n_mismatch = 0;
   int checks = 0;
   bwsc_top #(.AREAS(8)) DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cyc_start(cyc_start), .cyc_area(cyc_area),
      .cyc_kind(cyc_kind), .cyc_internal(cyc_internal), .wait_n(wait_n),
      .cyc_busy(cyc_busy), .cyc_done(cyc_done), .cyc_states(cyc_states));
   bwsc_mem_model u_mem (.clk(clk), .rst_n(rst_n), .cyc_busy(cyc_busy), .hold(hold),
      .wait_n(wait_n));
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   task automatic complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic chk(input string s, input logic [15:0] v, input logic [15:0] e);
      checks++;
      if (v !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", s, e, v);
      end
   endtask : chk
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0000, d};
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'h0);
      rd = avs_readdata[15:0];
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask : bus
   task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
      bus(1'h0, a, 16'h0000);
      chk("register", rd, e);
   endtask : rdchk
   task automatic cyc(input logic [2:0] a, input logic [2:0] k, input logic i,
      input logic [3:0] h, input logic [3:0] e);
      int n;
      n = 0;
      @(posedge clk);
      hold <= h;
      cyc_area <= a;
      cyc_kind <= k;
      cyc_internal <= i;
      cyc_start <= 1'h1;
      @(posedge clk);
      cyc_start <= 1'h0;
      do begin
         @(negedge clk);
         n++;
      end while (cyc_done !== 1'h1 && n < 40);
      chk("states", {12'h000, cyc_states}, {12'h000, e});
   endtask : cyc
   task automatic t_defaults;
      cyc(3, BWSC_K_DMA_RD, 0, 0, 2);
      cyc(3, BWSC_K_DMA_RD, 0, 3, 4);
      cyc(0, BWSC_K_DMA_RD, 0, 6, 7);
      cyc(5, BWSC_K_CPU_RD, 1, 5, 3);
      cyc(7, BWSC_K_CPU_RD, 1, 5, 1);
      cyc(0, BWSC_K_REFRESH, 0, 5, 3);
      cyc(6, BWSC_K_CPU_RD, 0, 0, 5);
   endtask : t_defaults
   task automatic t_regs;
      rdchk(BWSC_OFS_CPU_WAIT, 16'hFFFF);
      rdchk(BWSC_OFS_DMA_WAIT, 16'hFFFF);
      rdchk(BWSC_OFS_LONG_WAIT, 16'h7800);
      rdchk(5'h18, 16'h0000);
      bus(1, BWSC_OFS_AREA_CTRL, 16'h8000);
      bus(1, BWSC_OFS_CPU_WAIT, 16'h0000);
      rdchk(BWSC_OFS_CPU_WAIT, 16'h00FD);
      bus(1, BWSC_OFS_DMA_WAIT, 16'h0200);
      rdchk(BWSC_OFS_DMA_WAIT, 16'h0200);
   endtask : t_regs
   task automatic t_cleared;
      cyc(1, BWSC_K_CPU_WR, 0, 5, 1);
      cyc(4, BWSC_K_CPU_RD, 0, 5, 1);
      cyc(0, BWSC_K_CPU_RD, 0, 8, 5);
      cyc(0, BWSC_K_REFRESH, 0, 5, 1);
      cyc(1, BWSC_K_DMA_RD, 0, 0, 2);
      cyc(2, BWSC_K_DMA_RD, 0, 8, 5);
      cyc(3, BWSC_K_DMA_RD, 0, 5, 1);
      cyc(1, BWSC_K_DMA_WR, 0, 5, 1);
   endtask : t_cleared
   task automatic t_mixed;
      bus(1, BWSC_OFS_LONG_WAIT, 16'h2800);
      cyc(0, BWSC_K_DMA_RD, 0, 0, 3);
      cyc(6, BWSC_K_DMA_RD, 0, 0, 3);
      bus(1, BWSC_OFS_AREA_CTRL, 16'hC000);
      cyc(6, BWSC_K_DMA_RD, 0, 5, 6);
      bus(1, BWSC_OFS_CPU_WAIT, 16'hFF02);
      cyc(1, BWSC_K_CPU_WR, 0, 3, 4);
      bus(1, BWSC_OFS_REFRESH, 16'h0002);
      cyc(0, BWSC_K_REFRESH, 0, 5, 5);
      bus(1, BWSC_OFS_DMA_WAIT, 16'h00FF);
      cyc(4, BWSC_K_DMA_WR, 0, 3, 4);
   endtask : t_mixed
   initial begin
      rst_n = 1'h0;
      {avs_read, avs_write, cyc_start, cyc_internal} = 4'h0;
      avs_address = 5'h00;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      {cyc_area, cyc_kind, hold} = 10'h000;
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      t_defaults;
      t_regs;
      t_cleared;
      t_mixed;
      complete_run;
   end
   initial begin
      #100000;
      n_mismatch++;
      complete_run;
   end
endmodule : bus_wait_state_control_tb
